// ### sim/host_port_straps_and_eeprom_pins_tb.sv
// Self-checking bench: host end and device end joined pin to pin
`timescale 1ns/1ps
`default_nettype none
module host_port_straps_and_eeprom_pins_tb;
  localparam logic [15:0] MEM_WORD = 16'h0500;
  logic ref_clk = 1'b0;
  logic hostRstn = 1'b0;
  logic devRstn = 1'b0;
  logic [2:0] regAddr = 3'h0;
  logic [31:0] regWdata = 32'h0;
  logic regWrite = 1'b0;
  logic regRead = 1'b0;
  logic memDataIn = 1'b0;
  logic [31:0] regRdata;
  logic cfgLoaded, cfgMemPresent, busIs16, powerDown;
  logic prevClk = 1'b0;
  logic [4:0] riseNo = 5'h0;
  logic [8:0] cmdSeen = 9'h0;
  time riseT1 = 0;
  time riseT2 = 0;
  int nErrors = 0;
  int totalChecks = 0;

  hps_if #(.DATA_W(16)) link ();
  hps_device i_hps_device (.ref_clk(ref_clk), .rstn(devRstn), .link(link),
    .cfgLoaded(cfgLoaded), .cfgMemPresent(cfgMemPresent), .busIs16(busIs16),
    .powerDown(powerDown));
  hps_host i_hps_host (.ref_clk(ref_clk), .rstn(hostRstn), .link(link), .regAddr(regAddr),
    .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
    .memDataIn(memDataIn), .memClock(), .memSelect(), .memDataOut());
  hps_checker i_hps_checker (.ref_clk(ref_clk), .rstn(devRstn), .addrBus(link.addrBus),
    .addressQualifierN(link.addressQualifierN), .addressLatchStrobeN(link.addressLatchStrobeN),
    .asyncWriteStrobeN(link.asyncWriteStrobeN), .asyncReadStrobeN(link.asyncReadStrobeN),
    .hostDataOe(link.hostDataOe), .devDataOe(link.devDataOe),
    .localDeviceSelectN(link.localDeviceSelectN), .chipSleepN(link.chipSleepN),
    .cfgMemEnableStrap(link.cfgMemEnableStrap), .cfgMemSerialClock(link.cfgMemSerialClock),
    .cfgMemSelect(link.cfgMemSelect));

  initial begin
    forever #5 ref_clk = ~ref_clk;
  end

  // Serial memory: word out on falling clock; line toggles when deselected so no stale bit
  always @(posedge ref_clk) begin
    prevClk <= link.cfgMemSerialClock;
    if (!link.cfgMemSelect) begin
      riseNo <= 5'h0;
      memDataIn <= ~memDataIn;
    end else if (link.cfgMemSerialClock && !prevClk) begin
      riseNo <= riseNo + 5'h1;
      if (riseNo < 5'h9) cmdSeen <= {cmdSeen[7:0], link.cfgMemSerialOut};
      if (riseNo == 5'h0) riseT1 <= $time;
      if (riseNo == 5'h1) riseT2 <= $time;
    end else if (!link.cfgMemSerialClock && prevClk && riseNo >= 5'h9 && riseNo < 5'h19) begin
      memDataIn <= MEM_WORD[5'h18 - riseNo];
    end
  end

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    totalChecks++;
    if (seen !== exp) begin
      nErrors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic regWr(input logic [2:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regWdata <= d;
    regWrite <= 1'b1;
    @(posedge ref_clk);
    regWrite <= 1'b0;
  endtask : regWr

  task automatic regRd(input logic [2:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    regAddr <= a;
    regRead <= 1'b1;
    @(posedge ref_clk);
    regRead <= 1'b0;
    #1;
    d = regRdata;
  endtask : regRd

  // One device bus cycle through the host controller, waiting on its done flag
  task automatic busAcc(input logic wr, input logic [14:0] a, input logic [15:0] d,
                        output logic [15:0] rd);
    logic [31:0] s;
    regWr(hps_pkg::H_WDATA_IDX, {16'h0, d});
    regWr(hps_pkg::H_CMD_IDX, {15'h0, wr, 1'b0, a});
    s = 32'h0;
    for (int i = 0; i < 40 && s[1] !== 1'b1; i++) regRd(hps_pkg::H_STAT_IDX, s);
    regRd(hps_pkg::H_RDATA_IDX, s);
    rd = s[15:0];
  endtask : busAcc

  // Straps are set while the device is held in reset
  task automatic devReset(input logic [2:0] pins);
    @(posedge ref_clk);
    devRstn <= 1'b0;
    regWr(hps_pkg::H_PINS_IDX, {29'h0, pins});
    repeat (3) @(posedge ref_clk);
    devRstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
  endtask : devReset

  task automatic testNoMem();
    logic [15:0] rd;
    for (int w = 0; w < 2; w++) begin
      devReset({1'b1, w[0], 1'b0});
      check(32'(cfgMemPresent), 32'h0);
      check(32'(busIs16), 32'(w));
      check(32'(cfgLoaded), 32'h1);
      busAcc(1'b0, 15'h0182, 16'h0, rd);
      check(32'(rd), 32'h4 | 32'(w << 1));
    end
    $display("test no memory done");
  endtask : testNoMem

  task automatic testRegs();
    logic [15:0] rd;
    busAcc(1'b1, 15'h0181, 16'h0003, rd);
    check(32'(link.syncWriteReadSelect), 32'h1);
    busAcc(1'b0, 15'h0181, 16'h0, rd);
    check(32'(rd), 32'h3);
    busAcc(1'b0, 15'h0201, 16'h0, rd);
    check(32'(rd), 32'h0);
    $display("test registers done");
  endtask : testRegs

  task automatic testSleep();
    logic [15:0] rd;
    regWr(hps_pkg::H_PINS_IDX, 32'h2);
    repeat (3) @(posedge ref_clk);
    #1;
    check(32'(powerDown), 32'h1);
    busAcc(1'b0, 15'h0182, 16'h0, rd);
    check(32'(rd), 32'h0);
    regWr(hps_pkg::H_PINS_IDX, 32'h6);
    repeat (3) @(posedge ref_clk);
    #1;
    check(32'(powerDown), 32'h0);
    $display("test sleep done");
  endtask : testSleep

  // Load from memory moves the base; status is then read at the loaded base
  task automatic testMem();
    logic [15:0] rd;
    devReset(3'h5);
    for (int i = 0; i < 3000 && cfgLoaded !== 1'b1; i++) @(posedge ref_clk);
    #1;
    check(32'(cfgLoaded), 32'h1);
    check(32'(cfgMemPresent), 32'h1);
    check(32'(busIs16), 32'h0);
    check(32'(cmdSeen), 32'(hps_pkg::CMD_WORD));
    check(32'(riseT2 - riseT1), 32'(hps_pkg::SK_PERIOD_FAST_NS));
    busAcc(1'b0, 15'h0282, 16'h0, rd);
    check(32'(rd), 32'h5);
    $display("test memory load done");
  endtask : testMem

  task automatic stopTest();
    $display("checks %0d, mismatches %0d", totalChecks, nErrors);
    if (nErrors == 0 && totalChecks > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : stopTest

  // Watchdog: about three times the expected run
  initial begin
    #70000;
    nErrors++;
    stopTest();
  end

  initial begin
    repeat (6) @(posedge ref_clk);
    hostRstn <= 1'b1;
    testNoMem();
    testRegs();
    testSleep();
    testMem();
    stopTest();
  end
endmodule : host_port_straps_and_eeprom_pins_tb
`default_nettype wire

// ### sim/hps_checker.sv
// Pin-level assertions between the host end and the device end
`timescale 1ns/1ps
`default_nettype none
module hps_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [15:1] addrBus,
  input wire logic addressQualifierN,
  input wire logic addressLatchStrobeN,
  input wire logic asyncWriteStrobeN,
  input wire logic asyncReadStrobeN,
  input wire logic hostDataOe,
  input wire logic devDataOe,
  input wire logic localDeviceSelectN,
  input wire logic chipSleepN,
  input wire logic cfgMemEnableStrap,
  input wire logic cfgMemSerialClock,
  input wire logic cfgMemSelect
);
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);

  // Strobes only inside a qualified cycle
  property p_qual_strobe;
    !asyncWriteStrobeN || !asyncReadStrobeN |-> !addressQualifierN;
  endproperty
  a_qual_strobe: assert property (p_qual_strobe) else $error("strobe without qualifier");

  // Write data comes from the host alone
  property p_wr_data;
    !asyncWriteStrobeN |-> hostDataOe && !devDataOe;
  endproperty
  a_wr_data: assert property (p_wr_data) else $error("write strobe without host data");

  // Read strobe is four cycles long
  property p_rd_len;
    $fell(asyncReadStrobeN) |-> !asyncReadStrobeN [*4] ##1 asyncReadStrobeN;
  endproperty
  a_rd_len: assert property (p_rd_len) else $error("read strobe length wrong");

  // Device drives only after a selected read strobe
  property p_rd_drive;
    devDataOe |-> !$past(asyncReadStrobeN) && !$past(localDeviceSelectN);
  endproperty
  a_rd_drive: assert property (p_rd_drive) else $error("device drove without a read");

  // Two drivers on the data wire would fight
  property p_no_clash;
    !(devDataOe && hostDataOe);
  endproperty
  a_no_clash: assert property (p_no_clash) else $error("both ends drive data");

  // Address and qualifier held up to the latching edge
  property p_addr_hold;
    $rose(addressLatchStrobeN) |-> $stable(addrBus) && $stable(addressQualifierN);
  endproperty
  a_addr_hold: assert property (p_addr_hold) else $error("address moved at latch edge");

  // Memory is only selected when its strap says present
  property p_mem_strap;
    cfgMemSelect |-> cfgMemEnableStrap;
  endproperty
  a_mem_strap: assert property (p_mem_strap) else $error("memory selected while absent");

  // Serial clock rests low outside a load
  property p_clk_idle;
    !cfgMemSelect |-> !cfgMemSerialClock;
  endproperty
  a_clk_idle: assert property (p_clk_idle) else $error("serial clock ran while idle");

  // Loads run at the reset speed code, so each high phase is 40 cycles
  property p_half_fast;
    $rose(cfgMemSerialClock) |-> ##40 ($fell(cfgMemSerialClock) || !cfgMemSelect);
  endproperty
  a_half_fast: assert property (p_half_fast) else $error("serial clock high phase wrong");

  // Sleep delays by one cycle, so demand two sampled lows first
  property p_sleep_clk;
    !chipSleepN && !$past(chipSleepN) && !$past(chipSleepN, 2) |-> $stable(cfgMemSerialClock);
  endproperty
  a_sleep_clk: assert property (p_sleep_clk) else $error("serial clock moved asleep");

  // No read answer while powered down
  property p_sleep_quiet;
    !chipSleepN && !$past(chipSleepN) && !$past(chipSleepN, 2) |-> !devDataOe;
  endproperty
  a_sleep_quiet: assert property (p_sleep_quiet) else $error("device drove asleep");
endmodule : hps_checker
`default_nettype wire

// ### src/hps_device.sv
// Device end: strap capture, address latch and decode, registers, serial config load
// Contract
// RQ1: Memory-enable strap high means memory present
// RQ2: Drive serial data out to memory input
// RQ3: Speed code 11 gives 4 us clock
// RQ4: Speed code 00 gives 800 ns clock
// RQ5: Shift config data in on serial clock
// RQ6: No memory: serial input strap picks width
// RQ7: Sync select high writes, low reads
// RQ8: Decode only while address qualifier low
// RQ9: Accept write data under write strobe
// RQ10: Latch address, qualifier at strobe rising edge
// RQ11: Power down while sleep input low
// RQ12: Present read data while read strobe low
// RQ13: Select output decodes qualifier and base address
// RQ14: Sample straps, then load, after reset
//
// The register offsets and the strobed register port were left to the implementer.
`timescale 1ns/1ps
`default_nettype none
module hps_device #(
  parameter int DATA_W = 16,
  parameter bit BUS32 = 1'b0,
  parameter bit SYNC_BUS = 1'b0
) (
  input wire logic ref_clk,
  input wire logic rstn,
  hps_if.dev link,
  output logic cfgLoaded,
  output logic cfgMemPresent,
  output logic busIs16,
  output logic powerDown
);

  logic strapTaken_r, strapTaken_nxt;
  logic memEn_r, memEn_nxt;
  logic wide_r, wide_nxt;
  logic sleep_r, sleep_nxt;
  logic [15:1] latAddr_r, latAddr_nxt;
  logic latQual_r, latQual_nxt;
  logic wrPrev_r, wrPrev_nxt;
  logic adsPrev_r, adsPrev_nxt;
  logic syncPend_r, syncPend_nxt;
  logic syncDir_r, syncDir_nxt;
  logic [15:0] base_r, base_nxt;
  logic [1:0] speed_r, speed_nxt;
  logic [DATA_W-1:0] rdData_r, rdData_nxt;
  logic rdOe_r, rdOe_nxt;
  hps_pkg::hps_ser_type state_r, state_nxt;
  logic [8:0] halfCnt_r, halfCnt_nxt;
  logic [4:0] bitCnt_r, bitCnt_nxt;
  logic [15:0] shift_r, shift_nxt;
  logic sk_r, sk_nxt;
  logic cs_r, cs_nxt;
  logic so_r, so_nxt;
  logic loaded_r, loaded_nxt;

  logic sleeping;
  logic [15:1] effAddr;
  logic effQual;
  logic selected;
  logic narrow;
  logic hostWrite;
  logic [DATA_W-1:0] wrData;
  logic [8:0] halfLimit;
  logic tick;
  logic [15:0] regValue;

  // Sleep pin is taken as synchronous; low blocks decode and freezes the loader, but straps are still caught
  assign sleeping = ~link.chipSleepN; // RQ11

  // Straps are caught once, one edge after reset release, never under reset itself
  always_comb begin
    strapTaken_nxt = 1'b1;
    memEn_nxt = memEn_r;
    wide_nxt = wide_r;
    if (!strapTaken_r) begin
      memEn_nxt = link.cfgMemEnableStrap; // RQ1 RQ14
      wide_nxt = ~link.cfgMemEnableStrap & link.cfgMemSerialIn; // RQ6
    end
    sleep_nxt = sleeping;
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      strapTaken_r <= 1'b0;
      memEn_r <= 1'b0;
      wide_r <= 1'b0;
      sleep_r <= 1'b0;
    end else begin
      strapTaken_r <= strapTaken_nxt;
      memEn_r <= memEn_nxt;
      wide_r <= wide_nxt;
      sleep_r <= sleep_nxt;
    end
  end

  // Transparent while the latch strobe is low, frozen from its rising edge
  assign effAddr = link.addressLatchStrobeN ? latAddr_r : link.addrBus; // RQ10
  assign effQual = link.addressLatchStrobeN ? latQual_r : link.addressQualifierN; // RQ10
  // Width strap only matters outside 32-bit mode
  assign narrow = ~BUS32 & ~wide_r; // RQ6
  assign selected = ~effQual & (effAddr[15:4] == base_r[15:4]) & ~sleeping; // RQ8

  // Select is a pure decode, so it follows the pins with no clock delay
  assign link.localDeviceSelectN = ~selected; // RQ13

  // Write cycles: falling write strobe when async, select high after address strobe when sync
  always_comb begin
    hostWrite = 1'b0;
    if (SYNC_BUS) begin
      hostWrite = syncPend_r & syncDir_r; // RQ7
    end else begin
      hostWrite = wrPrev_r & ~link.asyncWriteStrobeN; // RQ9
    end
    hostWrite = hostWrite & selected & strapTaken_r;
    wrData = link.dataBus;
    if (narrow) begin
      wrData = {base_r[DATA_W-1:8], link.dataBus[7:0]};
    end
  end

  // Register read mux; unmapped words read zero, upper byte is zero in 8-bit mode
  always_comb begin
    regValue = 16'h0000;
    unique case (effAddr[3:1])
      hps_pkg::REG_BASE_IDX: regValue = base_r;
      hps_pkg::REG_SPEED_IDX: regValue = {14'h0000, speed_r};
      hps_pkg::REG_STATUS_IDX: begin
        regValue[hps_pkg::ST_MEM_EN] = memEn_r;
        regValue[hps_pkg::ST_WIDE] = wide_r;
        regValue[hps_pkg::ST_LOADED] = loaded_r;
        regValue[hps_pkg::ST_BUS32] = BUS32;
      end
      default: regValue = 16'h0000;
    endcase
    if (narrow) begin
      regValue[15:8] = 8'h00;
    end
  end

  // Bus front end: latch, edge history, sync cycle, read drive, register writes
  always_comb begin
    latAddr_nxt = latAddr_r;
    latQual_nxt = latQual_r;
    if (!link.addressLatchStrobeN) begin
      latAddr_nxt = link.addrBus; // RQ10
      latQual_nxt = link.addressQualifierN;
    end
    wrPrev_nxt = link.asyncWriteStrobeN;
    adsPrev_nxt = link.addressLatchStrobeN;
    syncPend_nxt = ~adsPrev_r & link.addressLatchStrobeN & SYNC_BUS;
    syncDir_nxt = syncDir_r;
    if (~adsPrev_r & link.addressLatchStrobeN) begin
      syncDir_nxt = link.syncWriteReadSelect; // RQ7
    end
    rdOe_nxt = 1'b0;
    if (selected & strapTaken_r) begin
      if (SYNC_BUS) begin
        rdOe_nxt = syncPend_r & ~syncDir_r; // RQ7
      end else begin
        rdOe_nxt = ~link.asyncReadStrobeN; // RQ12
      end
    end
    rdData_nxt = rdOe_nxt ? regValue[DATA_W-1:0] : '0;
    base_nxt = base_r;
    speed_nxt = speed_r;
    if (hostWrite) begin
      unique case (effAddr[3:1])
        hps_pkg::REG_BASE_IDX: base_nxt = wrData[15:0]; // RQ9
        hps_pkg::REG_SPEED_IDX: speed_nxt = wrData[1:0];
        default: base_nxt = base_r;
      endcase
    end
    // A finished load overrides a host write in the same cycle
    if ((state_r == hps_pkg::SER_DATA) & tick & ~sk_r &
        (bitCnt_r == 5'(hps_pkg::DATA_BITS - 1))) begin
      base_nxt = {shift_r[14:0], link.cfgMemSerialIn}; // RQ5
    end
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      latAddr_r <= '0;
      latQual_r <= 1'b1;
      wrPrev_r <= 1'b1;
      adsPrev_r <= 1'b1;
      syncPend_r <= 1'b0;
      syncDir_r <= 1'b0;
      rdOe_r <= 1'b0;
      rdData_r <= '0;
      base_r <= hps_pkg::BASE_RST;
      speed_r <= hps_pkg::SPEED_RST;
    end else begin
      latAddr_r <= latAddr_nxt;
      latQual_r <= latQual_nxt;
      wrPrev_r <= wrPrev_nxt;
      adsPrev_r <= adsPrev_nxt;
      syncPend_r <= syncPend_nxt;
      syncDir_r <= syncDir_nxt;
      rdOe_r <= rdOe_nxt;
      rdData_r <= rdData_nxt;
      base_r <= base_nxt;
      speed_r <= speed_nxt;
    end
  end

  // Half period of the serial clock from the bus speed code
  always_comb begin
    unique case (speed_r)
      hps_pkg::SPEED_125: halfLimit = hps_pkg::SK_HALF_FAST; // RQ4
      hps_pkg::SPEED_MID1: halfLimit = hps_pkg::SK_HALF_MID1;
      hps_pkg::SPEED_MID2: halfLimit = hps_pkg::SK_HALF_MID2;
      hps_pkg::SPEED_25: halfLimit = hps_pkg::SK_HALF_SLOW; // RQ3
    endcase
  end
  assign tick = (halfCnt_r == 9'(halfLimit - 9'h001));

  // Serial loader: command out on falling edges, data in on rising edges
  always_comb begin
    state_nxt = state_r;
    halfCnt_nxt = halfCnt_r;
    bitCnt_nxt = bitCnt_r;
    shift_nxt = shift_r;
    sk_nxt = sk_r;
    cs_nxt = cs_r;
    so_nxt = so_r;
    loaded_nxt = loaded_r;
    unique case (state_r)
      hps_pkg::SER_IDLE: begin
        if (strapTaken_r & ~sleeping) begin
          if (memEn_r) begin
            state_nxt = hps_pkg::SER_CMD; // RQ14
            cs_nxt = 1'b1;
            shift_nxt = {hps_pkg::CMD_WORD, 7'h00};
            so_nxt = hps_pkg::CMD_WORD[8]; // RQ2
            halfCnt_nxt = 9'h000;
            bitCnt_nxt = 5'h00;
          end else begin
            state_nxt = hps_pkg::SER_DONE; // RQ1
            loaded_nxt = 1'b1;
          end
        end
      end
      hps_pkg::SER_CMD, hps_pkg::SER_DATA: begin
        // Sleep freezes the clock mid-frame; the memory tolerates a stopped clock
        if (!sleeping) begin
          halfCnt_nxt = 9'(halfCnt_r + 9'h001);
          if (tick) begin
            halfCnt_nxt = 9'h000;
            sk_nxt = ~sk_r; // RQ3 RQ4
            if (!sk_r) begin
              bitCnt_nxt = 5'(bitCnt_r + 5'h01);
              if (state_r == hps_pkg::SER_CMD) begin
                if (bitCnt_r == 5'(hps_pkg::CMD_BITS - 1)) begin
                  state_nxt = hps_pkg::SER_DATA;
                  bitCnt_nxt = 5'h00;
                end
              end else begin
                shift_nxt = {shift_r[14:0], link.cfgMemSerialIn}; // RQ5
                if (bitCnt_r == 5'(hps_pkg::DATA_BITS - 1)) begin
                  state_nxt = hps_pkg::SER_DONE;
                  sk_nxt = 1'b0;
                  cs_nxt = 1'b0;
                  loaded_nxt = 1'b1;
                end
              end
            end else if (state_r == hps_pkg::SER_CMD) begin
              shift_nxt = {shift_r[14:0], 1'b0};
              so_nxt = shift_r[14]; // RQ2
            end else begin
              so_nxt = 1'b0;
            end
          end
        end
      end
      hps_pkg::SER_DONE: begin
        so_nxt = 1'b0;
      end
    endcase
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= hps_pkg::SER_IDLE;
      halfCnt_r <= 9'h000;
      bitCnt_r <= 5'h00;
      shift_r <= 16'h0000;
      sk_r <= 1'b0;
      cs_r <= 1'b0;
      so_r <= 1'b0;
      loaded_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      halfCnt_r <= halfCnt_nxt;
      bitCnt_r <= bitCnt_nxt;
      shift_r <= shift_nxt;
      sk_r <= sk_nxt;
      cs_r <= cs_nxt;
      so_r <= so_nxt;
      loaded_r <= loaded_nxt;
    end
  end

  // Pin and user-side outputs
  assign link.devData = rdData_r; // RQ12
  assign link.devDataOe = rdOe_r;
  assign link.cfgMemSerialOut = so_r; // RQ2
  assign link.cfgMemSerialClock = sk_r;
  assign link.cfgMemSelect = cs_r;
  assign cfgLoaded = loaded_r;
  assign cfgMemPresent = memEn_r;
  assign busIs16 = wide_r;
  assign powerDown = sleep_r;

endmodule : hps_device
`default_nettype wire

// ### src/hps_host.sv
// Host end: register-driven bus master, strap and sleep pins, memory data relay
`timescale 1ns/1ps
`default_nettype none
module hps_host #(
  parameter int DATA_W = 16,
  parameter int STROBE_CYCLES = hps_pkg::HOST_STROBE_CYCLES
) (
  input wire logic ref_clk,
  input wire logic rstn,
  hps_if.host link,
  input wire logic [2:0] regAddr,
  input wire logic [31:0] regWdata,
  input wire logic regWrite,
  input wire logic regRead,
  output logic [31:0] regRdata,
  input wire logic memDataIn,
  output logic memClock,
  output logic memSelect,
  output logic memDataOut
);

  hps_pkg::hps_hst_type state_r, state_nxt;
  logic [3:0] cnt_r, cnt_nxt;
  logic [15:1] addr_r, addr_nxt;
  logic isWrite_r, isWrite_nxt;
  logic [DATA_W-1:0] wdata_r, wdata_nxt;
  logic [DATA_W-1:0] rdata_r, rdata_nxt;
  logic done_r, done_nxt;
  logic [2:0] pins_r, pins_nxt;
  logic qualN_r, qualN_nxt;
  logic latN_r, latN_nxt;
  logic wsN_r, wsN_nxt;
  logic rsN_r, rsN_nxt;
  logic oe_r, oe_nxt;
  logic serIn_r, serIn_nxt;
  logic [31:0] out_r, out_nxt;
  logic mClk_r, mSel_r, mOut_r;

  // Register port, access sequencer and pin drive
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    addr_nxt = addr_r;
    isWrite_nxt = isWrite_r;
    wdata_nxt = wdata_r;
    rdata_nxt = rdata_r;
    done_nxt = done_r;
    pins_nxt = pins_r;
    qualN_nxt = qualN_r;
    latN_nxt = latN_r;
    wsN_nxt = wsN_r;
    rsN_nxt = rsN_r;
    oe_nxt = oe_r;
    out_nxt = 32'h00000000;
    if (regWrite) begin
      if (regAddr == hps_pkg::H_WDATA_IDX) wdata_nxt = regWdata[DATA_W-1:0];
      if (regAddr == hps_pkg::H_PINS_IDX) pins_nxt = regWdata[2:0];
    end
    if (regRead) begin
      unique case (regAddr)
        hps_pkg::H_RDATA_IDX: out_nxt = 32'(rdata_r);
        hps_pkg::H_STAT_IDX: out_nxt = {30'h00000000, done_r, state_r != hps_pkg::H_IDLE};
        hps_pkg::H_PINS_IDX: out_nxt = {28'h0000000, ~link.localDeviceSelectN, pins_r};
        default: out_nxt = 32'h00000000;
      endcase
      // Reading status clears done
      if (regAddr == hps_pkg::H_STAT_IDX) done_nxt = 1'b0;
    end
    unique case (state_r)
      hps_pkg::H_IDLE: begin
        // A command written while busy is dropped
        if (regWrite & (regAddr == hps_pkg::H_CMD_IDX)) begin
          state_nxt = hps_pkg::H_ADDR;
          addr_nxt = regWdata[14:0];
          isWrite_nxt = regWdata[hps_pkg::CMD_WRITE_BIT];
          qualN_nxt = 1'b0; // RQ8
          latN_nxt = 1'b0;
        end
      end
      hps_pkg::H_ADDR: begin
        // Rising latch strobe freezes address and qualifier in the device
        state_nxt = hps_pkg::H_STRB;
        latN_nxt = 1'b1; // RQ10
        wsN_nxt = ~isWrite_r; // RQ9
        rsN_nxt = isWrite_r; // RQ12
        oe_nxt = isWrite_r;
        cnt_nxt = 4'h0;
      end
      hps_pkg::H_STRB: begin
        cnt_nxt = 4'(cnt_r + 4'h1);
        if (cnt_r == 4'(STROBE_CYCLES - 1)) begin
          state_nxt = hps_pkg::H_END;
          if (!isWrite_r) rdata_nxt = link.dataBus; // RQ12
          wsN_nxt = 1'b1;
          rsN_nxt = 1'b1;
          oe_nxt = 1'b0;
          qualN_nxt = 1'b1;
        end
      end
      hps_pkg::H_END: begin
        state_nxt = hps_pkg::H_IDLE;
        done_nxt = 1'b1;
      end
    endcase
    // Without memory the serial input pin carries the width strap instead
    serIn_nxt = pins_r[0] ? memDataIn : pins_r[1]; // RQ6
  end

  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      state_r <= hps_pkg::H_IDLE;
      cnt_r <= 4'h0;
      addr_r <= '0;
      isWrite_r <= 1'b0;
      wdata_r <= '0;
      rdata_r <= '0;
      done_r <= 1'b0;
      pins_r <= hps_pkg::H_PINS_RST;
      qualN_r <= 1'b1;
      latN_r <= 1'b1;
      wsN_r <= 1'b1;
      rsN_r <= 1'b1;
      oe_r <= 1'b0;
      serIn_r <= 1'b0;
      out_r <= 32'h00000000;
      mClk_r <= 1'b0;
      mSel_r <= 1'b0;
      mOut_r <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      addr_r <= addr_nxt;
      isWrite_r <= isWrite_nxt;
      wdata_r <= wdata_nxt;
      rdata_r <= rdata_nxt;
      done_r <= done_nxt;
      pins_r <= pins_nxt;
      qualN_r <= qualN_nxt;
      latN_r <= latN_nxt;
      wsN_r <= wsN_nxt;
      rsN_r <= rsN_nxt;
      oe_r <= oe_nxt;
      serIn_r <= serIn_nxt;
      out_r <= out_nxt;
      mClk_r <= link.cfgMemSerialClock;
      mSel_r <= link.cfgMemSelect;
      mOut_r <= link.cfgMemSerialOut;
    end
  end

  // Pin drive from flops
  assign link.addrBus = addr_r;
  assign link.addressQualifierN = qualN_r;
  assign link.addressLatchStrobeN = latN_r;
  assign link.asyncWriteStrobeN = wsN_r;
  assign link.asyncReadStrobeN = rsN_r;
  assign link.syncWriteReadSelect = isWrite_r; // RQ7
  assign link.hostData = wdata_r;
  assign link.hostDataOe = oe_r;
  assign link.chipSleepN = pins_r[2];
  assign link.cfgMemEnableStrap = pins_r[0]; // RQ1
  assign link.cfgMemSerialIn = serIn_r; // RQ5
  assign regRdata = out_r;
  assign memClock = mClk_r;
  assign memSelect = mSel_r;
  assign memDataOut = mOut_r;

endmodule : hps_host
`default_nettype wire

// ### src/hps_if.sv
// Pin-level carrier between the host processor side and the device
`timescale 1ns/1ps
`default_nettype none
interface hps_if #(parameter int DATA_W = 16);
  logic [15:1] addrBus;
  logic addressQualifierN;
  logic addressLatchStrobeN;
  logic asyncWriteStrobeN;
  logic asyncReadStrobeN;
  logic syncWriteReadSelect;
  logic [DATA_W-1:0] hostData;
  logic hostDataOe;
  logic [DATA_W-1:0] devData;
  logic devDataOe;
  logic [DATA_W-1:0] dataBus;
  logic localDeviceSelectN;
  logic chipSleepN;
  logic cfgMemEnableStrap;
  logic cfgMemSerialIn;
  logic cfgMemSerialOut;
  logic cfgMemSerialClock;
  logic cfgMemSelect;

  // Shared data wire; an undriven bus reads as zero
  assign dataBus = devDataOe ? devData : (hostDataOe ? hostData : '0);

  modport dev (
    input addrBus, addressQualifierN, addressLatchStrobeN, asyncWriteStrobeN,
    input asyncReadStrobeN, syncWriteReadSelect, dataBus, chipSleepN,
    input cfgMemEnableStrap, cfgMemSerialIn,
    output devData, devDataOe, localDeviceSelectN, cfgMemSerialOut,
    output cfgMemSerialClock, cfgMemSelect
  );

  modport host (
    output addrBus, addressQualifierN, addressLatchStrobeN, asyncWriteStrobeN,
    output asyncReadStrobeN, syncWriteReadSelect, hostData, hostDataOe, chipSleepN,
    output cfgMemEnableStrap, cfgMemSerialIn,
    input dataBus, localDeviceSelectN, cfgMemSerialOut, cfgMemSerialClock, cfgMemSelect
  );
endinterface : hps_if
`default_nettype wire

// ### src/hps_pkg.sv
// Shared constants and types for the host port and configuration memory loader
package hps_pkg;

  // Reference clock rate in MHz
  localparam int CLK_MHZ = 100;

  // Serial memory clock periods per bus speed code, in ns
  localparam int SK_PERIOD_FAST_NS = 800;
  localparam int SK_PERIOD_MID1_NS = 1600;
  localparam int SK_PERIOD_MID2_NS = 3200;
  localparam int SK_PERIOD_SLOW_NS = 4000;

  // Half periods in reference clock cycles
  localparam logic [8:0] SK_HALF_FAST = 9'(SK_PERIOD_FAST_NS * CLK_MHZ / 1000 / 2);
  localparam logic [8:0] SK_HALF_MID1 = 9'(SK_PERIOD_MID1_NS * CLK_MHZ / 1000 / 2);
  localparam logic [8:0] SK_HALF_MID2 = 9'(SK_PERIOD_MID2_NS * CLK_MHZ / 1000 / 2);
  localparam logic [8:0] SK_HALF_SLOW = 9'(SK_PERIOD_SLOW_NS * CLK_MHZ / 1000 / 2);

  // Bus speed codes
  localparam logic [1:0] SPEED_125 = 2'h0;
  localparam logic [1:0] SPEED_MID1 = 2'h1;
  localparam logic [1:0] SPEED_MID2 = 2'h2;
  localparam logic [1:0] SPEED_25 = 2'h3;

  // Device register word indices (address bits 3:1)
  localparam logic [2:0] REG_BASE_IDX = 3'h0;
  localparam logic [2:0] REG_SPEED_IDX = 3'h1;
  localparam logic [2:0] REG_STATUS_IDX = 3'h2;
  localparam logic [15:0] BASE_RST = 16'h0300;
  localparam logic [1:0] SPEED_RST = 2'h0;

  // Status bit positions
  localparam int ST_MEM_EN = 0;
  localparam int ST_WIDE = 1;
  localparam int ST_LOADED = 2;
  localparam int ST_BUS32 = 3;

  // Serial read command: start bit, read opcode, word address zero
  localparam int CMD_BITS = 9;
  localparam logic [8:0] CMD_WORD = 9'h180;
  localparam int DATA_BITS = 16;

  // Host controller register indices and fields
  localparam logic [2:0] H_CMD_IDX = 3'h0;
  localparam logic [2:0] H_WDATA_IDX = 3'h1;
  localparam logic [2:0] H_RDATA_IDX = 3'h2;
  localparam logic [2:0] H_STAT_IDX = 3'h3;
  localparam logic [2:0] H_PINS_IDX = 3'h4;
  localparam int CMD_WRITE_BIT = 16;
  localparam logic [2:0] H_PINS_RST = 3'h4;
  localparam int HOST_STROBE_CYCLES = 4;

  // Serial loader states
  typedef enum logic [1:0] {
    SER_IDLE = 2'h0,
    SER_CMD = 2'h1,
    SER_DATA = 2'h3,
    SER_DONE = 2'h2
  } hps_ser_type;

  // Host access states
  typedef enum logic [1:0] {
    H_IDLE = 2'h0,
    H_ADDR = 2'h1,
    H_STRB = 2'h3,
    H_END = 2'h2
  } hps_hst_type;

endpackage : hps_pkg
